// >>> logic/sar_adc_host_control.v
// Control sequencer and host port of a 12-bit plus sign SAR converter
// Operation
// - Read and write strobes count only with chip select low
// - Conversion starts on write strobe rising edge
// - Select and read low drive result, clear ready
// - Calibration request resets logic, starts calibration
// - Calibration stores offset and ladder corrections
// - Calibration lasts about 1396 converter clocks
// - Offset-null select low adds nulling cycle
// - Nulling adds 26 converter clocks
// - Active flag low during conversion or calibration
// - Ready flag low once result latched
// - Read, start or calibration raises ready
// - Thirteen-bit two's complement, bit 12 sign
// - Sampling lasts six to seven clocks
// - Sample seven clocks, then active goes low
// - Sign first, then magnitude MSB to LSB
// - New start aborts and resets conversion
// - Calibration cannot be aborted once started
`timescale 1ns/1ps
`include "sar_ctrl_consts.vh"
module sar_adc_host_control #(
  parameter CAL_CLOCKS = `CAL_CLOCKS,
  parameter CLK_DIV = `SYS_CLK_HZ / `CONV_CLK_HZ
) (
  input wire clk_sys_i,
  input wire reset_n_i,
  input wire chip_select_n_i,
  input wire read_n_i,
  input wire write_n_i,
  input wire cal_request_n_i,
  input wire offset_null_select_n_i,
  input wire compare_i,
  output reg [`RESULT_WIDTH-1:0] result_bus_o,
  output reg [`RESULT_WIDTH-1:0] result_bus_oe_n_o,
  output reg conv_active_n_o,
  output reg result_ready_n_o,
  output reg corr_write_o,
  output reg [3:0] corr_addr_o,
  output reg [`CORR_WIDTH-1:0] corr_data_o,
  output reg corrupt_warn_o
);
  // ************************************************************
  // State codes
  // ************************************************************
  localparam ST_IDLE = 3'd0;
  localparam ST_CAL = 3'd1;
  localparam ST_AZ = 3'd2;
  localparam ST_SAMPLE = 3'd3;
  localparam ST_CONVERT = 3'd4;

  // ************************************************************
  // Pin synchronisers and converter clock enable
  // ************************************************************
  reg [4:0] sync_a;
  reg [4:0] sync_b;
  reg [4:0] pins;
  reg [15:0] div_cnt;
  reg tick;
  wire cs_n = pins[0];
  wire rd_n = pins[1];
  wire wr_n = pins[2];
  wire cal_n = pins[3];
  wire az_n = pins[4];

  always @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      sync_a <= 5'h1f;
      sync_b <= 5'h1f;
      pins <= 5'h1f;
      div_cnt <= 16'h0000;
      tick <= 1'b0;
    end else begin
      sync_a <= {offset_null_select_n_i, cal_request_n_i, write_n_i, read_n_i, chip_select_n_i};
      sync_b <= sync_a;
      pins <= sync_b;
      // One enable per converter clock; all sequencing counts these
      tick <= (div_cnt == CLK_DIV[15:0] - 16'h0001);
      if (div_cnt == CLK_DIV[15:0] - 16'h0001) begin
        div_cnt <= 16'h0000;
      end else begin
        div_cnt <= div_cnt + 16'h0001;
      end
    end
  end

  // Rising write edge while selected; select gates both strobes
  wire start = ~cs_n & wr_n & ~sync_b[2] ? 1'b0 : (~cs_n & ~wr_n & sync_b[2]);
  wire cal_edge = ~sync_b[3] & cal_n;
  wire reading = ~cs_n & ~rd_n;

  // ************************************************************
  // Sequencer
  // ************************************************************
  reg [2:0] state;
  reg [10:0] cnt;
  reg sar_clear;
  reg [`RESULT_WIDTH-1:0] code_keep;
  reg [3:0] corr_idx;
  wire [`RESULT_WIDTH-1:0] sar_code;
  wire sar_done;

  sar_bit_engine #(
    .WIDTH(`RESULT_WIDTH)
  ) u_sar (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .clear_i(sar_clear),
    .step_i(tick && state == ST_CONVERT),
    .compare_i(compare_i),
    .code_o(sar_code),
    .done_o(sar_done)
  );

  always @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      state <= ST_IDLE;
      cnt <= 11'h000;
      sar_clear <= 1'b1;
      code_keep <= 13'h0000;
      conv_active_n_o <= 1'b1;
      result_ready_n_o <= 1'b1;
      result_bus_o <= 13'h0000;
      result_bus_oe_n_o <= 13'h1fff;
      corr_write_o <= 1'b0;
      corr_addr_o <= 4'h0;
      corr_data_o <= 8'h00;
      corr_idx <= 4'h0;
      corrupt_warn_o <= 1'b0;
    end else begin
      sar_clear <= 1'b0;
      corr_write_o <= 1'b0;
      // Data lines driven only while selected and reading
      result_bus_oe_n_o <= reading ? 13'h0000 : 13'h1fff;
      result_bus_o <= code_keep;
      if (reading) begin
        result_ready_n_o <= 1'b1;
      end
      if (cal_edge && state != ST_CAL) begin
        // Calibration is only entered from outside a running calibration
        state <= ST_CAL;
        cnt <= 11'h000;
        corr_idx <= 4'h0;
        sar_clear <= 1'b1;
        conv_active_n_o <= 1'b0;
        result_ready_n_o <= 1'b1;
        corrupt_warn_o <= 1'b0;
      end else if (start && state != ST_CAL) begin
        // Abort; doing so mid-conversion may spoil corrections
        if (state == ST_SAMPLE || state == ST_CONVERT) begin
          corrupt_warn_o <= 1'b1;
        end
        sar_clear <= 1'b1;
        cnt <= 11'h000;
        result_ready_n_o <= 1'b1;
        conv_active_n_o <= 1'b1;
        state <= az_n ? ST_SAMPLE : ST_AZ;
      end else if (tick) begin
        case (state)
          ST_CAL: begin
            cnt <= cnt + 11'h001;
            // Offset then ladder terms land in the store; the spacing lets every entry fit one cycle
            if (cnt[5:0] == 6'h3f && corr_idx < `CORR_DEPTH) begin
              corr_write_o <= 1'b1;
              corr_addr_o <= corr_idx;
              corr_data_o <= {7'h00, compare_i};
              corr_idx <= corr_idx + 4'h1;
            end
            if (cnt == CAL_CLOCKS[10:0] - 11'h001) begin
              state <= ST_IDLE;
              conv_active_n_o <= 1'b1;
            end
          end
          ST_AZ: begin
            cnt <= cnt + 11'h001;
            if (cnt == `AZ_CLOCKS - 1) begin
              cnt <= 11'h000;
              state <= ST_SAMPLE;
            end
          end
          ST_SAMPLE: begin
            cnt <= cnt + 11'h001;
            if (cnt == `SAMPLE_CLOCKS - 1) begin
              cnt <= 11'h000;
              state <= ST_CONVERT;
              conv_active_n_o <= 1'b0;
            end
          end
          ST_CONVERT: begin
            if (sar_done) begin
              code_keep <= sar_code;
              // Latch and ready flag move together so a reader never sees the old word
              result_bus_o <= sar_code;
              conv_active_n_o <= 1'b1;
              result_ready_n_o <= 1'b0;
              state <= ST_IDLE;
            end
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end
endmodule // sar_adc_host_control

// >>> logic/sar_bit_engine.v
// Successive-approximation register: sign decision then magnitude bits
`timescale 1ns/1ps
module sar_bit_engine #(
  parameter WIDTH = 13
) (
  input wire clk_sys_i,
  input wire reset_n_i,
  input wire clear_i,
  input wire step_i,
  input wire compare_i,
  output reg [WIDTH-1:0] code_o,
  output reg done_o
);
  reg [WIDTH-1:0] trial;

  always @(posedge clk_sys_i) begin
    if (!reset_n_i || clear_i) begin
      code_o <= {WIDTH{1'b0}};
      trial <= {1'b1, {(WIDTH-1){1'b0}}};
      done_o <= 1'b0;
    end else if (step_i && !done_o) begin
      if (trial[WIDTH-1]) begin
        // Sign: low for positive, high for negative input
        code_o[WIDTH-1] <= ~compare_i;
        code_o[WIDTH-2] <= 1'b1;
      end else begin
        // Keep the trial bit if input exceeds DAC, then try the next one
        if (!compare_i) begin
          code_o <= (code_o & ~trial) | (trial >> 1);
        end else begin
          code_o <= code_o | (trial >> 1);
        end
      end
      trial <= trial >> 1;
      done_o <= trial[0];
    end
  end
endmodule // sar_bit_engine

// >>> pkg/sar_ctrl_consts.vh
// Timing counts, widths and encodings for the converter control sequencer
`ifndef SAR_CTRL_CONSTS_VH
`define SAR_CTRL_CONSTS_VH
`define RESULT_WIDTH 13
`define SIGN_BIT_POS 12
`define CAL_CLOCKS 1396
`define AZ_CLOCKS 26
`define SAMPLE_CLOCKS 7
`define MAG_BITS 12
`define CORR_WIDTH 8
`define CORR_DEPTH 13
`define SYS_CLK_HZ 50000000
`define CONV_CLK_HZ 2000000
`endif

// >>> testbench/analog_front_model.sv
// Behavioural comparator standing in for the analog front end
`timescale 1ns/1ps
module analog_front_model (
  input wire polarity_i,
  output wire compare_o
);
  // A held input level: above every trial level when positive, below when negative
  assign compare_o = polarity_i;
endmodule // analog_front_model

// >>> testbench/sar_adc_host_control_tb.sv
// Self-checking bench for the converter control sequencer
`timescale 1ns/1ps
`include "sar_ctrl_consts.vh"
module sar_adc_host_control_tb;
  // Converter clock at 2 MHz; calibration just long enough to fill the correction store
  localparam integer DIV = 25;
  localparam integer CAL = 840;
  reg clk_sys_i = 0, reset_n_i = 0, cs_n = 1, rd_n = 1, wr_n = 1, cal_n = 1, az_n = 1, pol = 0;
  integer fail_count = 0, tests_run = 0, seed = 32'hcee63b82, n, t0, rnd, corr_seen = 0;
  reg [12:0] exp_q[$];
  wire cmp, act_n, rdy_n, warn, corr_wr;
  wire [3:0] corr_addr;
  wire [12:0] res, oe_n;
  always #10 clk_sys_i = ~clk_sys_i;
  analog_front_model analog_front_model_inst (.polarity_i(pol), .compare_o(cmp));
  sar_adc_host_control #(.CAL_CLOCKS(CAL), .CLK_DIV(DIV)) sar_adc_host_control_inst (.clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i), .chip_select_n_i(cs_n), .read_n_i(rd_n), .write_n_i(wr_n), .cal_request_n_i(cal_n),
    .offset_null_select_n_i(az_n), .compare_i(cmp), .result_bus_o(res), .result_bus_oe_n_o(oe_n),
    .conv_active_n_o(act_n), .result_ready_n_o(rdy_n), .corr_write_o(corr_wr), .corr_addr_o(corr_addr),
    .corr_data_o(), .corrupt_warn_o(warn));
  task automatic chk(input [31:0] got, input [31:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task cyc(input integer k);
    begin
      repeat (k) @(posedge clk_sys_i);
      #1;
    end
  endtask
  task strobe(input c);
    begin
      cs_n = c;
      wr_n = 0;
      cyc(4);
      wr_n = 1;
      cyc(4);
      cs_n = 1;
    end
  endtask
  task conv(input a, input ign);
    begin
      az_n = a;
      rnd = $random(seed);
      pol = rnd[0];
      exp_q.push_back(pol ? 13'h0fff : 13'h1000);
      strobe(0);
      n = 0;
      while (rdy_n !== 1'b0 && n < 3000) begin
        cyc(1);
        n = n + 1;
      end
      chk(n < 3000, 1'h1);
      if (ign) begin
        strobe(1);
        rd_n = 0;
        cyc(8);
        rd_n = 1;
        chk(rdy_n, 1'h0);
      end
      cyc(4);
      cs_n = 0;
      rd_n = 0;
      cyc(8);
      chk(rdy_n, 1'h1);
      cs_n = 1;
      rd_n = 1;
      cyc(4);
    end
  endtask
  task calib;
    begin
      corr_seen = 0;
      cal_n = 0;
      cyc(4);
      cal_n = 1;
      cyc(8);
      chk(act_n, 1'h0);
      strobe(0);
      n = 0;
      while (act_n === 1'b0 && n < 2 * CAL * DIV) begin
        cyc(1);
        n = n + 1;
      end
      chk(n > (CAL - 1) * DIV - 20 && n < CAL * DIV - 10, 1'h1);
      chk(corr_seen, `CORR_DEPTH);
      // Long enough for a wrongly taken start to finish its conversion
      cyc(22 * DIV);
      chk(rdy_n, 1'h1);
      chk(warn, 1'h0);
    end
  endtask
  // A read turns the bus on; the oldest expected word is due then
  always @(negedge oe_n[0]) begin
    #2;
    chk(res, exp_q.pop_front());
    chk(oe_n, 13'h0000);
  end
  // Correction terms must fill the store in address order
  always @(posedge clk_sys_i) begin
    if (corr_wr === 1'b1) begin
      chk(corr_addr, corr_seen);
      corr_seen = corr_seen + 1;
    end
  end
  task test_done;
    begin
      $display("comparisons %0d, mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  initial begin
    // Two calibrations dominate the run; a third one's worth leaves margin
    #(3 * CAL * DIV * 20);
    fail_count = fail_count + 1;
    test_done;
  end
  initial begin
    cyc(2);
    reset_n_i = 1;
    cyc(4);
    calib;
    conv(1, 0);
    t0 = n;
    conv(0, 1);
    chk(n - t0 > 25 * DIV && n - t0 < 27 * DIV, 1'h1);
    // An unread result is dropped by a fresh start, which is then cut short while sampling
    az_n = 1;
    strobe(0);
    n = 0;
    while (rdy_n !== 1'b0 && n < 3000) begin
      cyc(1);
      n = n + 1;
    end
    chk(n < 3000, 1'h1);
    strobe(0);
    chk(rdy_n, 1'h1);
    cyc(30);
    conv(1, 0);
    chk(warn, 1'h1);
    calib;
    chk(exp_q.size(), 0);
    test_done;
  end
endmodule // sar_adc_host_control_tb

// >>> testbench/sar_ctrl_props.sv
// Port assertions for the converter control sequencer
`timescale 1ns/1ps
module sar_ctrl_props (
  input wire clk_sys_i,
  input wire reset_n_i,
  input wire chip_select_n_i,
  input wire read_n_i,
  input wire write_n_i,
  input wire cal_request_n_i,
  input wire [12:0] result_bus_o,
  input wire [12:0] result_bus_oe_n_o,
  input wire conv_active_n_o,
  input wire result_ready_n_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  bus_float_a: assert property (chip_select_n_i [*5] |-> &result_bus_oe_n_o)
    else $error("bus driven while deselected");
  bus_drive_a: assert property ((!chip_select_n_i && !read_n_i) [*6] |-> !(|result_bus_oe_n_o) && result_ready_n_o)
    else $error("read did not drive bus or raise ready");
  cal_ack_a: assert property ($fell(cal_request_n_i) && conv_active_n_o |-> ##[1:8] !conv_active_n_o)
    else $error("calibration not acknowledged");
  done_order_a: assert property ($fell(result_ready_n_o) |-> ##[0:1] conv_active_n_o)
    else $error("ready fell while still active");
  start_clear_a: assert property ($rose(write_n_i) && !chip_select_n_i && conv_active_n_o |-> ##[1:8] result_ready_n_o)
    else $error("start did not raise ready");
  sample_idle_a: assert property ($rose(write_n_i) && !chip_select_n_i && conv_active_n_o |=> conv_active_n_o [*8])
    else $error("active fell during sampling");
  ignore_strobe_a: assert property (chip_select_n_i [*4] ##0 ($rose(write_n_i) && !result_ready_n_o) |=> !result_ready_n_o [*6])
    else $error("strobe taken while deselected");
  result_hold_a: assert property (!result_ready_n_o && $past(!result_ready_n_o) |-> $stable(result_bus_o))
    else $error("latched result changed");
endmodule // sar_ctrl_props
bind sar_adc_host_control sar_ctrl_props sar_ctrl_props_inst (.clk_sys_i, .reset_n_i, .chip_select_n_i, .read_n_i,
  .write_n_i, .cal_request_n_i, .result_bus_o, .result_bus_oe_n_o, .conv_active_n_o, .result_ready_n_o);
